/* File: accr_pkg.sv */
package accr_pkg;

  // ----------------------------------------------------------------
  // Register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_MISC1 = 8'h01;
  localparam logic [7:0] OFS_MISC2 = 8'h02;
  localparam logic [7:0] OFS_SAP = 8'h03;
  localparam logic [7:0] NUM_REGS = 8'h04;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_MISC1 = 8'h32;
  localparam logic [7:0] RST_MISC2 = 8'h62;
  localparam logic [7:0] RST_SAP = 8'h04;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MODE_RST_BIT = 7;
  localparam int MODE_LO_BIT = 3;
  localparam int M1_HPF_BIT = 7;
  localparam int M1_OTW_LSB = 5;
  localparam int M1_OC_BIT = 4;
  localparam int M1_RAMP_LSB = 2;
  localparam int M1_GAIN_LSB = 0;
  localparam int M2_PWM_LSB = 4;
  localparam int M2_OSR_BIT = 2;
  localparam int SAP_RATE_LSB = 6;
  localparam int SAP_SLOT_LSB = 3;
  localparam int SAP_FMT_LSB = 0;

  // Bus address of the device; the value is arbitrary.
  localparam logic [6:0] I2C_DEV_ADDR = 7'h6A;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FMT_RIGHT = 2'b00,
    FMT_I2S = 2'b01,
    FMT_LEFT = 2'b10,
    FMT_DSP = 2'b11
  } accr_fmt_t;

  typedef struct packed {
    logic line_output_select;
    logic highpass_skip;
    logic [1:0] overtemp_warn_threshold;
    logic [7:0] overtemp_deg_c;
    logic [1:0] overcurrent_level_select;
    logic [3:0] ramp_frames_per_step;
    logic [1:0] gain_code;
    logic [8:0] gain_peak_dv;
    logic [5:0] switch_multiple;
    logic switch_code_ok;
    logic [7:0] modulator_oversample_ratio;
    logic [1:0] sample_rate_select;
    logic [3:0] slot_number;
    accr_fmt_t fmt_kind;
    logic [4:0] fmt_word_bits;
    logic fmt_ok;
  } accr_cfg_t;

endpackage

/* File: accr_regs.sv */
`timescale 1ns/1ps
// Contract
// - Writing one to mode bit 7 resets the device; the bit reads zero.
// - Mode bit 3 picks speaker mode at zero, line output mode at one.
// - Bit 7 of first misc register at one bypasses the high-pass filter.
// - Misc bits 6-5 set warning temperature 140, 130, 120 or 110 C.
// - Misc bit 4 picks overcurrent level one or two; two after reset.
// - Misc bits 3-2 give one volume step per 1, 2, 4, 8 frame syncs.
// - Misc bits 1-0 give peak output 7.5, 15, 21 or 29 volts.
// - Second misc bits 6-4 give switching multiple 8, 10, 38 or 44.
// - Code 111 gives 48 times, 44.1 kHz only; codes 010-100 are reserved.
// - Second misc bit 2 picks oversampling of 64 or 128 times.
// - Port bits 5-3 pick TDM slot 1 to 8, or I2S channel 1 or 2.
// - Format codes 000-011 give right-justified words of 24, 20, 18, 16.
// - Codes 100, 101, 110 give I2S, left justified, DSP; 111 reserved.
// - Mode register resets to 0x00.
// - First misc register resets to 0x32.
// - Second misc register resets to 0x62.
// - Serial port register resets to 0x04.
// - Each acknowledged write byte advances the register pointer by one.
module accr_regs
  import accr_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Two-wire bus pins.
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Configuration towards the amplifier core.
  output accr_cfg_t cfg,
  output logic device_reset
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_DEV = 4'b0001,
    ST_DEV_ACK = 4'b0010,
    ST_SUB = 4'b0011,
    ST_SUB_ACK = 4'b0100,
    ST_WR = 4'b0101,
    ST_WR_ACK = 4'b0110,
    ST_RD = 4'b0111,
    ST_RD_ACK = 4'b1000
  } accr_state_t;

  // ----------------------------------------------------------------
  // Pin synchronisers and bus conditions
  // ----------------------------------------------------------------
  logic scl_s1_reg;
  logic scl_s2_reg;
  logic scl_s3_reg;
  logic sda_s1_reg;
  logic sda_s2_reg;
  logic sda_s3_reg;

  always_ff @(posedge clock) begin
    scl_s1_reg <= scl_in;
    scl_s2_reg <= scl_s1_reg;
    scl_s3_reg <= scl_s2_reg;
    sda_s1_reg <= sda_in;
    sda_s2_reg <= sda_s1_reg;
    sda_s3_reg <= sda_s2_reg;
  end

  wire scl_rise = scl_s2_reg & ~scl_s3_reg;
  wire scl_fall = ~scl_s2_reg & scl_s3_reg;
  wire scl_high = scl_s2_reg & scl_s3_reg;
  wire bus_start = scl_high & sda_s3_reg & ~sda_s2_reg;
  wire bus_stop = scl_high & ~sda_s3_reg & sda_s2_reg;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] regs_reg [0:3];
  logic soft_rst_reg;
  logic [7:0] ptr_reg;
  logic [7:0] shift_reg;
  logic wr_en;

  wire ptr_mapped = ptr_reg < NUM_REGS;
  wire wr_mode = wr_en && ptr_reg == OFS_MODE;
  // The reset bit is never stored, so it always reads back as zero.
  wire [7:0] wr_val = wr_mode ? {1'b0, shift_reg[6:0]} : shift_reg;
  // Unmapped offsets read as zero and ignore writes.
  wire [7:0] rd_byte = ptr_mapped ? regs_reg[ptr_reg[1:0]] : 8'h00;

  always_ff @(posedge clock) begin
    if (rst || soft_rst_reg) begin
      regs_reg[0] <= RST_MODE;
      regs_reg[1] <= RST_MISC1;
      regs_reg[2] <= RST_MISC2;
      regs_reg[3] <= RST_SAP;
    end else if (wr_en && ptr_mapped) begin
      regs_reg[ptr_reg[1:0]] <= wr_val;
    end
  end

  // The soft reset lasts one cycle and leaves the bus engine running, so
  // the acknowledge of the byte that asked for it still completes.
  always_ff @(posedge clock) begin
    if (rst) begin
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= wr_mode && shift_reg[MODE_RST_BIT];
    end
  end

  assign device_reset = soft_rst_reg;

  // ----------------------------------------------------------------
  // Bus engine
  // ----------------------------------------------------------------
  accr_state_t state_reg;
  accr_state_t state_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [7:0] shift_next;
  logic [7:0] ptr_next;
  logic oe_reg;
  logic oe_next;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    ptr_next = ptr_reg;
    oe_next = oe_reg;
    wr_en = 1'b0;
    if (bus_stop) begin
      state_next = ST_IDLE;
      oe_next = 1'b0;
    end else if (bus_start) begin
      state_next = ST_DEV;
      cnt_next = 4'h0;
      oe_next = 1'b0;
    end else if (scl_rise) begin
      case (state_reg)
        ST_DEV, ST_SUB, ST_WR: begin
          shift_next = {shift_reg[6:0], sda_s2_reg};
          cnt_next = 4'(cnt_reg + 4'h1);
        end
        ST_RD_ACK: begin
          if (sda_s2_reg) begin
            state_next = ST_IDLE;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (state_reg)
        ST_DEV: begin
          if (cnt_reg == 4'h8) begin
            if (shift_reg[7:1] == I2C_DEV_ADDR) begin
              state_next = ST_DEV_ACK;
              oe_next = 1'b1;
            end else begin
              state_next = ST_IDLE;
            end
          end
        end
        ST_DEV_ACK: begin
          if (shift_reg[0]) begin
            state_next = ST_RD;
            shift_next = rd_byte;
            oe_next = ~rd_byte[7];
            cnt_next = 4'h1;
          end else begin
            state_next = ST_SUB;
            oe_next = 1'b0;
            cnt_next = 4'h0;
          end
        end
        ST_SUB: begin
          if (cnt_reg == 4'h8) begin
            state_next = ST_SUB_ACK;
            oe_next = 1'b1;
            ptr_next = shift_reg;
          end
        end
        ST_WR: begin
          if (cnt_reg == 4'h8) begin
            state_next = ST_WR_ACK;
            oe_next = 1'b1;
            wr_en = 1'b1;
            ptr_next = 8'(ptr_reg + 8'h01);
          end
        end
        ST_SUB_ACK, ST_WR_ACK: begin
          state_next = ST_WR;
          oe_next = 1'b0;
          cnt_next = 4'h0;
        end
        ST_RD: begin
          if (cnt_reg == 4'h8) begin
            state_next = ST_RD_ACK;
            oe_next = 1'b0;
            ptr_next = 8'(ptr_reg + 8'h01);
          end else begin
            shift_next = {shift_reg[6:0], 1'b0};
            oe_next = ~shift_reg[6];
            cnt_next = 4'(cnt_reg + 4'h1);
          end
        end
        ST_RD_ACK: begin
          state_next = ST_RD;
          shift_next = rd_byte;
          oe_next = ~rd_byte[7];
          cnt_next = 4'h1;
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      oe_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      ptr_reg <= ptr_next;
      oe_reg <= oe_next;
    end
  end

  // Open-drain: the line is only ever pulled low.
  assign sda_out = 1'b0;
  assign sda_oe = oe_reg;

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  wire [7:0] mode_r = regs_reg[0];
  wire [7:0] misc1_r = regs_reg[1];
  wire [7:0] misc2_r = regs_reg[2];
  wire [7:0] sap_r = regs_reg[3];
  wire [1:0] otw_code = misc1_r[M1_OTW_LSB +: 2];
  wire [1:0] ramp_code = misc1_r[M1_RAMP_LSB +: 2];
  wire [1:0] gain_code = misc1_r[M1_GAIN_LSB +: 2];
  wire [2:0] pwm_code = misc2_r[M2_PWM_LSB +: 3];
  wire [1:0] rate_code = sap_r[SAP_RATE_LSB +: 2];
  wire [2:0] fmt_code = sap_r[SAP_FMT_LSB +: 3];

  assign cfg.line_output_select = mode_r[MODE_LO_BIT];
  assign cfg.highpass_skip = misc1_r[M1_HPF_BIT];
  assign cfg.overtemp_warn_threshold = otw_code;
  assign cfg.overtemp_deg_c = (otw_code == 2'h0) ? 8'h8C :
                              (otw_code == 2'h1) ? 8'h82 :
                              (otw_code == 2'h2) ? 8'h78 : 8'h6E;
  assign cfg.overcurrent_level_select = misc1_r[M1_OC_BIT] ? 2'h2 : 2'h1;
  assign cfg.ramp_frames_per_step = 4'(4'h1 << ramp_code);
  assign cfg.gain_code = gain_code;
  assign cfg.gain_peak_dv = (gain_code == 2'h0) ? 9'h04B :
                            (gain_code == 2'h1) ? 9'h096 :
                            (gain_code == 2'h2) ? 9'h0D2 : 9'h122;
  // Reserved switching codes report a zero multiple and are flagged bad.
  assign cfg.switch_multiple = (pwm_code == 3'h0) ? 6'h08 :
                               (pwm_code == 3'h1) ? 6'h0A :
                               (pwm_code == 3'h5) ? 6'h26 :
                               (pwm_code == 3'h6) ? 6'h2C :
                               (pwm_code == 3'h7) ? 6'h30 : 6'h00;
  assign cfg.switch_code_ok = (pwm_code == 3'h7) ? (rate_code == 2'h0) :
                              (cfg.switch_multiple != 6'h00);
  assign cfg.modulator_oversample_ratio = misc2_r[M2_OSR_BIT] ? 8'h80 : 8'h40;
  assign cfg.sample_rate_select = rate_code;
  assign cfg.slot_number = 4'({1'b0, sap_r[SAP_SLOT_LSB +: 3]} + 4'h1);
  assign cfg.fmt_kind = fmt_code[2] ? accr_fmt_t'(fmt_code[1:0] + 2'h1) : FMT_RIGHT;
  assign cfg.fmt_word_bits = (fmt_code == 3'h0) ? 5'h18 :
                             (fmt_code == 3'h1) ? 5'h14 :
                             (fmt_code == 3'h2) ? 5'h12 :
                             (fmt_code == 3'h3) ? 5'h10 : 5'h00;
  assign cfg.fmt_ok = fmt_code != 3'h7;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  soft_reset_a: assert property (wr_mode && shift_reg[7] |=> device_reset ##1
    !device_reset && misc1_r == RST_MISC1 && mode_r[7] == 1'b0)
    else $error("Soft reset failed.");
  line_mode_a: assert property (wr_mode && !shift_reg[7] |=>
    cfg.line_output_select == $past(shift_reg[3]))
    else $error("Line mode wrong.");
  hpf_skip_a: assert property (wr_en && ptr_reg == OFS_MISC1 |=>
    cfg.highpass_skip == $past(shift_reg[M1_HPF_BIT]))
    else $error("Filter bypass wrong.");
  otw_temp_a: assert property (otw_code == 2'h3 |->
    cfg.overtemp_deg_c == 8'h6E)
    else $error("Warning threshold wrong.");
  oc_level_a: assert property (cfg.overcurrent_level_select ==
    {misc1_r[4], ~misc1_r[4]})
    else $error("Overcurrent level wrong.");
  ramp_pace_a: assert property (ramp_code == 2'h3 |->
    cfg.ramp_frames_per_step == 4'h8)
    else $error("Ramp pace wrong.");
  gain_peak_a: assert property (gain_code == 2'h2 |->
    cfg.gain_peak_dv == 9'h0D2)
    else $error("Gain wrong.");
  pwm_mult_a: assert property (pwm_code == 3'h6 |->
    cfg.switch_multiple == 6'h2C && cfg.switch_code_ok)
    else $error("Switch multiple wrong.");
  pwm_resv_a: assert property (pwm_code inside {3'h2, 3'h3, 3'h4} ||
    (pwm_code == 3'h7 && rate_code != 2'h0) |-> !cfg.switch_code_ok)
    else $error("Reserved switch code accepted.");
  osr_sel_a: assert property (misc2_r[2] |->
    cfg.modulator_oversample_ratio == 8'h80)
    else $error("Oversampling wrong.");
  slot_sel_a: assert property (sap_r[5:3] == 3'h7 |->
    cfg.slot_number == 4'h8)
    else $error("Slot wrong.");
  rj_width_a: assert property (fmt_code == 3'h2 |->
    cfg.fmt_word_bits == 5'h12 && cfg.fmt_kind == FMT_RIGHT)
    else $error("Word width wrong.");
  fmt_kind_a: assert property (fmt_code == 3'h6 |->
    cfg.fmt_kind == FMT_DSP && cfg.fmt_ok)
    else $error("Format wrong.");
  mode_reset_a: assert property ($fell(rst) |->
    mode_r == 8'h00)
    else $error("Mode reset wrong.");
  misc1_reset_a: assert property ($fell(rst) |->
    misc1_r == 8'h32)
    else $error("Misc1 reset wrong.");
  misc2_reset_a: assert property ($fell(rst) |->
    misc2_r == 8'h62)
    else $error("Misc2 reset wrong.");
  sap_reset_a: assert property ($fell(rst) |->
    sap_r == 8'h04)
    else $error("Port reset wrong.");
  ptr_incr_a: assert property (wr_en |=>
    ptr_reg == 8'($past(ptr_reg) + 8'h01))
    else $error("Pointer not advanced.");
  unmapped_wr_a: assert property (wr_en && !ptr_mapped |=>
    $stable(mode_r) && $stable(misc1_r) && $stable(misc2_r) && $stable(sap_r))
    else $error("Unmapped write landed.");
  // A stuck pull-down would block every other bus user, so idle must release.
  idle_release_a: assert property (state_reg == ST_IDLE |->
    !sda_oe)
    else $error("Data line held while idle.");

  write_misc_c: cover property (wr_en && ptr_reg == OFS_MISC1);
  read_byte_c: cover property (state_reg == ST_RD_ACK && scl_fall);
  soft_reset_c: cover property (device_reset);
  read_more_c: cover property (state_reg == ST_RD_ACK && scl_rise && !sda_s2_reg);
  write_seq_c: cover property (wr_en && ptr_reg == OFS_SAP);

endmodule

/* File: accr_host.sv */
`timescale 1ns/1ps
module accr_host (
  // Clock.
  clock,
  // Device pull-down on the data line.
  sda_oe,
  sda_out,
  // Bus line levels.
  scl_line,
  sda_line
);
  input wire logic clock;
  input wire logic sda_oe;
  input wire logic sda_out;
  output logic scl_line;
  output wire logic sda_line;
  // ----------------------------------------------------------------
  // Open-drain lines
  // ----------------------------------------------------------------
  logic sda_drv = 1'b1;
  initial scl_line = 1'b1;
  // Both parties only pull low; a released line reads the pull-up level.
  assign sda_line = sda_drv & (sda_oe ? sda_out : 1'b1);
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // Phases of six cycles keep well above the four-cycle minimum of the device.
  task automatic waitc(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  task automatic start_c(input logic rep);
    if (rep) begin
      sda_drv = 1'b1;
      waitc(6);
      scl_line = 1'b1;
      waitc(6);
    end
    sda_drv = 1'b0;
    waitc(6);
    scl_line = 1'b0;
    waitc(3);
  endtask
  task automatic stop_c();
    sda_drv = 1'b0;
    waitc(6);
    scl_line = 1'b1;
    waitc(6);
    sda_drv = 1'b1;
    waitc(6);
  endtask
  // Data changes mid-low so it is never mistaken for a start or stop.
  task automatic bit_c(input logic b, output logic r);
    sda_drv = b;
    waitc(6);
    scl_line = 1'b1;
    waitc(6);
    r = sda_line;
    scl_line = 1'b0;
    waitc(3);
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_c(d[i], r);
    end
    bit_c(1'b1, r);
    ack = ~r;
  endtask
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_c(1'b1, d[i]);
    end
    bit_c(last, r);
  endtask
endmodule

/* File: amp_core_config_registers_bench.sv */
`timescale 1ns/1ps
module amp_core_config_registers_bench import accr_pkg::*;;
  logic clock = 1'b0;
  logic rst = 1'b1;
  wire logic scl_line;
  wire logic sda_line;
  logic sda_oe;
  logic sda_out;
  logic device_reset;
  accr_cfg_t cfg;
  int n_errors = 0;
  int check_count = 0;
  int resets_seen = 0;
  logic ack;
  logic [7:0] deg [4] = '{8'h8C, 8'h82, 8'h78, 8'h6E};
  logic [8:0] gain [4] = '{9'h04B, 9'h096, 9'h0D2, 9'h122};
  logic [2:0] pwm [5] = '{3'h0, 3'h1, 3'h5, 3'h6, 3'h7};
  logic [5:0] mult [5] = '{6'h08, 6'h0A, 6'h26, 6'h2C, 6'h30};
  logic [1:0] kind [7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3};
  logic [4:0] wbits [7] = '{5'h18, 5'h14, 5'h12, 5'h10, 5'h00, 5'h00, 5'h00};
  always #12.5 clock = ~clock;
  accr_regs u_dut (.clock(clock), .rst(rst), .scl_in(scl_line), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .cfg(cfg), .device_reset(device_reset));
  accr_host u_host (.clock(clock), .sda_oe(sda_oe), .sda_out(sda_out), .scl_line(scl_line),
    .sda_line(sda_line));
  always @(posedge clock) if (device_reset === 1'b1) resets_seen <= resets_seen + 1;
  // ----------------------------------------------------------------
  // Checking and register access
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      $display("MISMATCH at %0t: %s got %0h expected %0h", $time, what, got, exp);
      n_errors++;
    end
  endtask
  task automatic head(input logic [7:0] sub);
    u_host.start_c(1'b0);
    u_host.put_byte({I2C_DEV_ADDR, 1'b0}, ack);
    chk(16'(ack), 16'h0001, "address ack");
    u_host.put_byte(sub, ack);
    chk(16'(ack), 16'h0001, "offset ack");
  endtask
  task automatic wr(input logic [7:0] sub, input logic [7:0] d[$]);
    head(sub);
    foreach (d[i]) begin
      u_host.put_byte(d[i], ack);
      chk(16'(ack), 16'h0001, "data ack");
    end
    u_host.stop_c();
  endtask
  task automatic rd(input logic [7:0] sub, input logic [7:0] e[$]);
    logic [7:0] v;
    head(sub);
    u_host.start_c(1'b1);
    u_host.put_byte({I2C_DEV_ADDR, 1'b1}, ack);
    chk(16'(ack), 16'h0001, "read address ack");
    foreach (e[i]) begin
      u_host.get_byte(i == e.size() - 1, v);
      chk(16'(v), 16'(e[i]), "read data");
    end
    u_host.stop_c();
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  // The host only waits on the clock, so a hung bus engine cannot stall it; a watchdog still caps the run at 90000 cycles.
  initial begin
    repeat (90000) @(posedge clock);
    $display("MISMATCH at %0t: run did not finish", $time);
    n_errors++;
    close_out();
  end
  initial begin
    logic [1:0] k;
    int base_resets;
    logic [7:0] v;
    repeat (8) @(posedge clock);
    #2;
    rst = 1'b0;
    repeat (4) @(posedge clock);
    #2;
    rd(OFS_MODE, '{RST_MODE, RST_MISC1, RST_MISC2, RST_SAP});
    chk(16'(cfg.overcurrent_level_select), 16'h0002, "oc default");
    chk(16'(cfg.switch_multiple), 16'h002C, "pwm default");
    chk(16'(cfg.fmt_kind), 16'(FMT_I2S), "format default");
    chk(16'(sda_out), 16'h0000, "open drain level");
    $display("test defaults done");
    wr(OFS_MODE, '{8'h08});
    chk(16'(cfg.line_output_select), 16'h0001, "line output");
    for (int i = 0; i < 4; i++) begin
      k = 2'(i);
      v = {k[0], k, k[1], k, k};
      wr(OFS_MISC1, '{v});
      chk(16'(cfg.highpass_skip), 16'(k[0]), "filter skip");
      chk(16'(cfg.overtemp_deg_c), 16'(deg[i]), "warn temp");
      chk(16'(cfg.overcurrent_level_select), 16'(k[1] ? 2'h2 : 2'h1), "oc level");
      chk(16'(cfg.ramp_frames_per_step), 16'h0001 << i, "ramp pace");
      chk(16'(cfg.gain_peak_dv), 16'(gain[i]), "gain");
      chk(16'(cfg.gain_code), 16'(k), "gain code");
      chk(16'(cfg.overtemp_warn_threshold), 16'(k), "warn code");
    end
    $display("test misc1 fields done");
    for (int i = 0; i < 5; i++) begin
      wr(OFS_MISC2, '{{1'b0, pwm[i], 1'b0, 1'(i), 2'b10}});
      chk(16'(cfg.switch_multiple), 16'(mult[i]), "pwm multiple");
      chk(16'(cfg.switch_code_ok), 16'h0001, "pwm valid");
      chk(16'(cfg.modulator_oversample_ratio), i[0] ? 16'h0080 : 16'h0040, "osr");
    end
    $display("test misc2 fields done");
    for (int i = 0; i < 8; i++) begin
      wr(OFS_SAP, '{{2'b00, 3'(i), 3'(i % 7)}});
      chk(16'(cfg.slot_number), 16'(i + 1), "slot");
      chk(16'(cfg.fmt_kind), 16'(kind[i % 7]), "format kind");
      chk(16'(cfg.fmt_word_bits), 16'(wbits[i % 7]), "word bits");
      chk(16'(cfg.fmt_ok), 16'h0001, "format valid");
    end
    wr(OFS_SAP, '{8'h44});
    chk(16'(cfg.switch_code_ok), 16'h0000, "pwm 48x at 48 kHz");
    chk(16'(cfg.sample_rate_select), 16'h0001, "rate code");
    $display("test serial port fields done");
    wr(OFS_MODE, '{8'h00, 8'hB3, 8'h52, 8'h0C});
    rd(OFS_MODE, '{8'h00, 8'hB3, 8'h52, 8'h0C});
    wr(8'h05, '{8'hAA});
    rd(8'h05, '{8'h00});
    u_host.start_c(1'b0);
    u_host.put_byte({7'h15, 1'b0}, ack);
    chk(16'(ack), 16'h0000, "foreign address nack");
    u_host.stop_c();
    $display("test sequential and refused access done");
    base_resets = resets_seen;
    wr(OFS_MODE, '{8'h88});
    chk(16'(resets_seen - base_resets), 16'h0001, "reset pulse count");
    rd(OFS_MODE, '{RST_MODE, RST_MISC1, RST_MISC2, RST_SAP});
    chk(16'(cfg.line_output_select), 16'h0000, "mode after reset");
    $display("test soft reset done");
    close_out();
  end
endmodule
